// ---- verilog/iodr_port.sv ----
// I/O port top: register slave over a plain port and pin drive for N groups
`timescale 1ns/1ns
module iodr_port
	import iodr_pkg::*;
#(
	parameter int GROUPS = 2,
	parameter int PINS = 32
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [11:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output iodr_pin_s [GROUPS-1:0] pins
);
	initial begin
		if (GROUPS < 1 || GROUPS > 32)
			$error("GROUPS must be 1..32");
	end

	logic [31:0] dir_w [GROUPS];
	logic [31:0] lvl_w [GROUPS];
	logic [31:0] pen_w [GROUPS];
	logic [4:0] grp;
	logic [6:0] ofs;

	// Group index from the 0x80 stride, offset inside the group
	assign grp = addr[11:7];
	assign ofs = addr[6:0];

	// Reading a register needs the group's state and the word offset
	function automatic logic [31:0] reg_read(input logic [6:0] o,
		input logic [31:0] d, input logic [31:0] l, input logic [31:0] p);
		logic [31:0] r;
		r = 32'h0;
		if (o[1:0] == 2'h0) begin
			if (o[6:4] == 3'h0)
				r = d;
			else if (o[6:4] == 3'h1)
				r = l;
			else if (o == IODR_OFS_PULL_ENA)
				r = p;
		end
		return r;
	endfunction

	for (genvar g = 0; g < GROUPS; g++) begin : gen_grp
		logic gwr;
		// Misaligned writes are dropped rather than aliased
		assign gwr = wr && grp == 5'(g) && ofs[1:0] == 2'h0;
		iodr_group #(.PINS(PINS)) u_grp (
			.clk(clk),
			.srst(srst),
			.wr(gwr),
			.ofs(ofs),
			.wdata(wdata),
			.dir_q(dir_w[g]),
			.lvl_q(lvl_w[g]),
			.pull_ena_q(pen_w[g])
		);
		// Pin drive from direction, level and pull enable
		always_ff @(posedge clk) begin
			if (srst) begin
				pins[g] <= '0;
			end else begin
				pins[g].oe <= dir_w[g];
				pins[g].out <= lvl_w[g] & dir_w[g];
				pins[g].pull_en <= pen_w[g] & ~dir_w[g];
				pins[g].pull_up <= lvl_w[g] & pen_w[g] & ~dir_w[g];
			end
		end
	end

	// Read data one cycle after the strobe, zero otherwise or unmapped
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata <= IODR_RST_WORD;
		end else begin
			rdata <= 32'h0;
			for (int g = 0; g < GROUPS; g++) begin
				if (rd && grp == 5'(g))
					rdata <= reg_read(ofs, dir_w[g], lvl_w[g], pen_w[g]);
			end
		end
	end

	a_read_dir: assert property (@(posedge clk) disable iff (srst)
		rd && grp == 5'h0 && ofs == IODR_OFS_DIRFLIP
		|=> rdata == dir_w[0]) else $error("flip alias read wrong");
	a_pin_drive: assert property (@(posedge clk) disable iff (srst)
		##1 pins[0].out == ($past(lvl_w[0]) & $past(dir_w[0])))
		else $error("pin drive wrong");
	a_pull_dir: assert property (@(posedge clk) disable iff (srst)
		##1 pins[0].pull_up == ($past(lvl_w[0]) & $past(pen_w[0])
		& ~$past(dir_w[0]))) else $error("pull direction wrong");
	c_read_lvl: cover property (@(posedge clk)
		rd && ofs == IODR_OFS_LVLCLR);
	c_group1: cover property (@(posedge clk) wr && grp == 5'h1);
endmodule

// ---- verilog/iodr_pkg.sv ----
// Package: register map, reset values and bus carrier for the I/O port block
package iodr_pkg;
	localparam int IODR_DATA_W = 32;
	localparam int IODR_ADDR_W = 12;
	localparam logic [11:0] IODR_GROUP_STRIDE = 12'h080;
	localparam logic [6:0] IODR_OFS_DIR = 7'h00;
	localparam logic [6:0] IODR_OFS_DIR_CLR = 7'h04;
	localparam logic [6:0] IODR_OFS_DIR_SET = 7'h08;
	localparam logic [6:0] IODR_OFS_DIRFLIP = 7'h0c;
	localparam logic [6:0] IODR_OFS_LVL = 7'h10;
	localparam logic [6:0] IODR_OFS_LVLCLR = 7'h14;
	localparam logic [6:0] IODR_OFS_LVLSET = 7'h18;
	localparam logic [6:0] IODR_OFS_LVLFLIP = 7'h1c;
	localparam logic [6:0] IODR_OFS_PULL_ENA = 7'h20;
	localparam logic [31:0] IODR_RST_WORD = 32'h0000_0000;

	// One register access from software
	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} iodr_req_s;

	// Pin drive state of one group
	typedef struct packed {
		logic [31:0] out;
		logic [31:0] oe;
		logic [31:0] pull_en;
		logic [31:0] pull_up;
	} iodr_pin_s;
endpackage

// ---- verilog/iodr_group.sv ----
// One pin group: direction and drive level state with set/clear/flip aliases
`timescale 1ns/1ns
module iodr_group
	import iodr_pkg::*;
#(
	parameter int PINS = 32
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic wr,
	input wire logic [6:0] ofs,
	input wire logic [31:0] wdata,
	output logic [31:0] dir_q,
	output logic [31:0] lvl_q,
	output logic [31:0] pull_ena_q
);
	initial begin
		if (PINS < 1 || PINS > 32)
			$error("PINS must be 1..32");
	end

	localparam logic [31:0] PIN_MASK = 32'hffff_ffff >> (32 - PINS);

	// Apply a plain, clear, set or flip write; in the clear, set and flip aliases zero bits keep their value
	function automatic logic [31:0] upd(input logic [31:0] cur,
		input logic [1:0] op, input logic [31:0] w);
		logic [31:0] r;
		r = cur;
		unique case (op)
			2'h0: r = w;
			2'h1: r = cur & ~w;
			2'h2: r = cur | w;
			2'h3: r = cur ^ w;
		endcase
		return r & PIN_MASK;
	endfunction

	// Direction vector: one state behind all four addresses
	always_ff @(posedge clk) begin
		if (srst)
			dir_q <= IODR_RST_WORD;
		else if (wr && ofs[6:4] == 3'h0)
			dir_q <= upd(dir_q, ofs[3:2], wdata);
	end

	// Drive level vector: one state behind all four addresses
	always_ff @(posedge clk) begin
		if (srst)
			lvl_q <= IODR_RST_WORD;
		else if (wr && ofs[6:4] == 3'h1)
			lvl_q <= upd(lvl_q, ofs[3:2], wdata);
	end

	// Pull enable, kept beside the level so it can pick pull direction
	always_ff @(posedge clk) begin
		if (srst)
			pull_ena_q <= IODR_RST_WORD;
		else if (wr && ofs == IODR_OFS_PULL_ENA)
			pull_ena_q <= wdata & PIN_MASK;
	end

	a_flip_dir: assert property (@(posedge clk) disable iff (srst)
		wr && ofs == IODR_OFS_DIRFLIP |=> dir_q == ($past(dir_q)
		^ ($past(wdata) & PIN_MASK))) else $error("dir flip wrong");
	a_clr_lvl: assert property (@(posedge clk) disable iff (srst)
		wr && ofs == IODR_OFS_LVLCLR |=> lvl_q == ($past(lvl_q)
		& ~$past(wdata))) else $error("level clear wrong");
	a_flip_lvl: assert property (@(posedge clk) disable iff (srst)
		wr && ofs == IODR_OFS_LVLFLIP |=> lvl_q == ($past(lvl_q)
		^ ($past(wdata) & PIN_MASK))) else $error("level flip wrong");
	a_set_dir: assert property (@(posedge clk) disable iff (srst)
		wr && ofs == IODR_OFS_DIR_SET |=> dir_q == ($past(dir_q)
		| ($past(wdata) & PIN_MASK))) else $error("dir set wrong");
	a_clr_dir: assert property (@(posedge clk) disable iff (srst)
		wr && ofs == IODR_OFS_DIR_CLR |=> dir_q == ($past(dir_q)
		& ~$past(wdata))) else $error("dir clear wrong");
	a_set_lvl: assert property (@(posedge clk) disable iff (srst)
		wr && ofs == IODR_OFS_LVLSET |=> lvl_q == ($past(lvl_q)
		| ($past(wdata) & PIN_MASK))) else $error("level set wrong");
	a_dir_hold: assert property (@(posedge clk) disable iff (srst)
		!(wr && ofs[6:4] == 3'h0) |=> $stable(dir_q))
		else $error("dir moved without write");
	a_lvl_hold: assert property (@(posedge clk) disable iff (srst)
		!(wr && ofs[6:4] == 3'h1) |=> $stable(lvl_q))
		else $error("level moved without write");
	c_dir_flip: cover property (@(posedge clk)
		wr && ofs == IODR_OFS_DIRFLIP && wdata != 32'h0);
	c_lvl_clr: cover property (@(posedge clk)
		wr && ofs == IODR_OFS_LVLCLR && lvl_q != 32'h0);
	c_lvl_flip: cover property (@(posedge clk)
		wr && ofs == IODR_OFS_LVLFLIP && wdata != 32'h0);
endmodule

// ---- tb/iodr_pads.sv ----
// Far-side pad model: pin drivers and pull resistors of one group
`timescale 1ns/1ns
module iodr_pads
	import iodr_pkg::*;
(
	input wire logic clk,
	input wire iodr_pin_s pin,
	output logic [31:0] pad
);
	logic [31:0] float_q = 32'h0;
	// Loose pads wander so a stale level never passes for a real one
	always_ff @(posedge clk) begin
		float_q <= ~float_q;
	end
	// Driver wins, then the pull resistor, else the wandering level
	assign pad = (pin.oe & pin.out) |
		(~pin.oe & pin.pull_en & pin.pull_up) |
		(~pin.oe & ~pin.pull_en & float_q);
endmodule

// ---- tb/iodr_port_bench.sv ----
// Self-checking bench: random register traffic against a reference model
`timescale 1ns/1ns
module iodr_port_bench;
	import iodr_pkg::*;
	logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [11:0] addr = 12'h000, a;
	logic [31:0] wdata = 32'h0, rdata, pad, ex;
	iodr_pin_s [1:0] pins;
	logic [31:0] m_dir [2], m_lvl [2], m_pul [2];
	logic [6:0] offs [10] = '{7'h00, 7'h04, 7'h08, 7'h0c, 7'h10, 7'h14,
		7'h18, 7'h1c, 7'h20, 7'h24};
	int mismatches = 0, compares = 0;

	// Free-running clock, 40 ns period
	always #20 clk = ~clk;

	iodr_port #(.GROUPS(2), .PINS(32)) u_dut (.clk(clk), .srst(srst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.pins(pins));
	iodr_pads u_pads (.clk(clk), .pin(pins[0]), .pad(pad));

	task print_verdict;
		if (mismatches == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task check(input logic [127:0] got, input logic [127:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Model read: aliases show the shared state, unmapped places read 0
	function automatic logic [31:0] mread(input logic [11:0] ad);
		int g;
		g = int'(ad[11:7]);
		if (g > 1)
			return 32'h0;
		case (ad[6:0])
			7'h00, 7'h04, 7'h08, 7'h0c: return m_dir[g];
			7'h10, 7'h14, 7'h18, 7'h1c: return m_lvl[g];
			7'h20: return m_pul[g];
			default: return 32'h0;
		endcase
	endfunction

	task bus_wr(input logic [11:0] ad, input logic [31:0] d);
		int g;
		g = int'(ad[11:7]);
		@(posedge clk);
		wr <= 1'b1;
		addr <= ad;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1 check({96'h0, rdata}, 128'h0);
		if (g < 2 && ad[1:0] == 2'h0) begin
			case (ad[6:0])
				7'h00: m_dir[g] = d;
				7'h04: m_dir[g] &= ~d;
				7'h08: m_dir[g] |= d;
				7'h0c: m_dir[g] ^= d;
				7'h10: m_lvl[g] = d;
				7'h14: m_lvl[g] &= ~d;
				7'h18: m_lvl[g] |= d;
				7'h1c: m_lvl[g] ^= d;
				7'h20: m_pul[g] = d;
				default: ;
			endcase
		end
	endtask

	task bus_rd(input logic [11:0] ad);
		@(posedge clk);
		rd <= 1'b1;
		addr <= ad;
		@(posedge clk);
		rd <= 1'b0;
		#1 check({96'h0, rdata}, {96'h0, mread(ad)});
	endtask

	// Reset, register reset values, then random alias traffic
	initial begin
		void'($urandom(37669));
		for (int g = 0; g < 2; g++) begin
			m_dir[g] = 32'h0;
			m_lvl[g] = 32'h0;
			m_pul[g] = 32'h0;
		end
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 40; i++)
			bus_rd({5'(i / 10), offs[i % 10]});
		repeat (400) begin
			a = {5'($urandom_range(3)), offs[$urandom_range(9)]};
			// Now and then a misaligned write, which must be dropped
			if ($urandom_range(7) == 0)
				a[1:0] = 2'($urandom_range(1, 3));
			bus_wr(a, $urandom());
			bus_rd({5'($urandom_range(3)), offs[$urandom_range(9)]});
			for (int g = 0; g < 2; g++)
				check(pins[g], {m_lvl[g] & m_dir[g], m_dir[g],
					m_pul[g] & ~m_dir[g],
					m_lvl[g] & m_pul[g] & ~m_dir[g]});
			ex = m_dir[0] | m_pul[0];
			check({96'h0, pad & ex}, {96'h0, m_lvl[0] & ex});
		end
		print_verdict();
	end

	// Watchdog well beyond the expected run of about 1700 cycles
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		print_verdict();
	end
endmodule
